// ==== include/canc_pkg.sv ====
package canc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned MCLK_PERIOD_NS = 8;
  localparam int unsigned SLEEP_SYNC_NS = 32;
  localparam int unsigned SLEEP_SYNC_CYC = (SLEEP_SYNC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [2:0] SYNC_LAST = 3'(SLEEP_SYNC_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_CTRL1 = 8'h04;
  localparam logic [7:0] A_RFLG = 8'h08;
  localparam logic [7:0] A_RIER = 8'h0c;
  localparam logic [7:0] A_TFLG = 8'h10;
  localparam logic [7:0] A_TIER = 8'h14;
  localparam logic [7:0] A_TXERR = 8'h18;
  localparam logic [7:0] A_RXERR = 8'h1c;
  localparam logic [3:0] ACC_PAGE = 4'h2;
  localparam logic [3:0] MSK_PAGE = 4'h3;
  localparam logic [7:0] A_FG_ID = 8'h40;
  localparam logic [7:0] A_FG_INFO = 8'h44;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int B_INIT_REQ = 0;
  localparam int B_SLEEP_REQ = 1;
  localparam int B_WAKE_EN = 2;
  localparam int B_STOP_WAIT = 3;
  localparam int B_INIT_ACK = 8;
  localparam int B_SLEEP_ACK = 9;
  localparam int B_MOD_EN = 0;
  localparam int B_LISTEN = 1;
  localparam int B_LOOP = 2;
  localparam int B_PDOWN = 3;
  localparam int B_WAKE_FLAG = 0;
  localparam int B_STATUS_FLAG = 1;
  localparam int B_OVERRUN = 2;
  localparam int B_RX_FULL = 3;
  localparam int B_RX_STATE = 4;
  localparam int B_TX_STATE = 6;
  localparam int B_ABORT = 8;
  localparam int RIE_WUP = 0;
  localparam int RIE_CSC = 1;
  localparam int RIE_OVR = 2;
  localparam int RIE_RX_FULL = 3;

  ////////////////////////////////////////////////////////////////////////
  // error counter ranges
  localparam logic [7:0] ERR_WARN = 8'h60;
  localparam logic [7:0] ERR_PASSIVE = 8'h80;
  localparam logic [1:0] BUS_OK = 2'h0;
  localparam logic [1:0] BUS_WARN = 2'h1;
  localparam logic [1:0] BUS_PASSIVE = 2'h2;
  localparam logic [1:0] BUS_OFF = 2'h3;

  typedef enum logic [1:0] {S_RUN, S_DRAIN, S_SYNC, S_SLEEP} canc_phase_t;

  typedef struct packed {
    logic tx_bit;
    logic bus_idle;
    logic rx_done;
    logic rx_ide;
    logic [31:0] rx_id;
    logic [2:0] tx_done;
    logic [7:0] tec;
    logic [7:0] rec;
    logic bus_off;
  } canc_mac_in_t;

  typedef struct packed {
    logic rx_bit;
    logic clk_run;
    logic [2:0] tx_request;
    logic [2:0] abort_request;
    logic ignore_ack;
  } canc_mac_out_t;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic tx_pin;
    logic init_req;
    logic init_ack;
    logic slp_req;
    logic wake_en;
    logic stop_wait;
    logic mod_en;
    logic listen;
    logic loop;
    logic pdown;
    logic wake_flag;
    logic status_flag;
    logic overrun_flag;
    logic rx_full;
    logic [1:0] rx_state;
    logic [1:0] tx_state;
    logic [3:0] rier;
    logic [2:0] tx_empty;
    logic [2:0] abort;
    logic [2:0] tier;
    logic [3:0][7:0] acc;
    logic [3:0][7:0] msk;
    logic bg_new;
    logic bg_ide;
    logic [31:0] bg_id;
    logic pend_valid;
    logic pend_ide;
    logic [31:0] pend_id;
    logic fg_ide;
    logic [31:0] fg_id;
    canc_phase_t phase;
    logic [2:0] sync_cnt;
    logic [31:0] prdata;
  } canc_state_t;

  localparam canc_state_t STATE_RST = '{
    rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1, tx_pin: 1'b1,
    init_req: 1'b1, tx_empty: 3'h7, phase: S_RUN, default: '0};

endpackage

// ==== hw/canc_byte_match.sv ====
`timescale 1ns/1ps
module canc_byte_match (
  // filter pair and received byte
  input wire logic [7:0] acc,
  input wire logic [7:0] msk,
  input wire logic [7:0] id,
  // result
  output logic hit
);
  // a set mask bit makes that position a don't-care
  assign hit = &(~(acc ^ id) | msk);
endmodule

// ==== hw/canc_core.sv ====
`timescale 1ns/1ps
module canc_core (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can pins
  input wire logic bus_rx_pin,
  output logic bus_tx_pin,
  // protocol engine
  input wire canc_pkg::canc_mac_in_t mac_in,
  output canc_pkg::canc_mac_out_t mac_out,
  // power
  input wire logic cpu_wait,
  output logic reg_clk_run,
  // interrupt requests
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_rx,
  output logic irq_tx
);

  canc_pkg::canc_state_t s;
  canc_pkg::canc_state_t next_s;
  logic [3:0] hit;
  logic accept;
  logic move;
  logic in_init;
  logic sleep_ack;
  logic tx_allowed;
  logic wr;
  logic mapped;
  logic [31:0] rd_val;
  logic [1:0] rx_state_now;
  logic [1:0] tx_state_now;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  assign in_init = s.init_req & s.init_ack;
  assign sleep_ack = (s.phase == canc_pkg::S_SLEEP);
  assign wr = psel & penable & pwrite;
  // no transmit start once the sleep delay runs, so the outcome is fixed
  assign tx_allowed = s.mod_en & ~s.listen & ~s.init_req & ~in_init &
    ((s.phase == canc_pkg::S_RUN) | (s.phase == canc_pkg::S_DRAIN));

  ////////////////////////////////////////////////////////////////////////
  // acceptance filter

  for (genvar i = 0; i < 4; i++) begin : g_match
    canc_byte_match u_match (
      .acc(s.acc[i]),
      .msk(s.msk[i]),
      .id(s.bg_id[31-8*i -: 8]),
      .hit(hit[i])
    );
  end

  // standard frames ignore the last two pairs
  assign accept = s.bg_new & hit[0] & hit[1] & (~s.bg_ide | (hit[2] & hit[3]));
  assign move = s.pend_valid & ~s.rx_full & ~sleep_ack;

  ////////////////////////////////////////////////////////////////////////
  // error counter ranges

  always_comb begin
    if (mac_in.rec >= canc_pkg::ERR_PASSIVE) begin
      rx_state_now = canc_pkg::BUS_PASSIVE;
    end else if (mac_in.rec >= canc_pkg::ERR_WARN) begin
      rx_state_now = canc_pkg::BUS_WARN;
    end else begin
      rx_state_now = canc_pkg::BUS_OK;
    end
    if (mac_in.bus_off) begin
      tx_state_now = canc_pkg::BUS_OFF;
    end else if (mac_in.tec >= canc_pkg::ERR_PASSIVE) begin
      tx_state_now = canc_pkg::BUS_PASSIVE;
    end else if (mac_in.tec >= canc_pkg::ERR_WARN) begin
      tx_state_now = canc_pkg::BUS_WARN;
    end else begin
      tx_state_now = canc_pkg::BUS_OK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    if (paddr[7:4] == canc_pkg::ACC_PAGE) begin
      rd_val[7:0] = s.acc[paddr[3:2]];
    end else if (paddr[7:4] == canc_pkg::MSK_PAGE) begin
      rd_val[7:0] = s.msk[paddr[3:2]];
    end else if (paddr == canc_pkg::A_CTRL0) begin
      rd_val[canc_pkg::B_INIT_REQ] = s.init_req;
      rd_val[canc_pkg::B_SLEEP_REQ] = s.slp_req;
      rd_val[canc_pkg::B_WAKE_EN] = s.wake_en;
      rd_val[canc_pkg::B_STOP_WAIT] = s.stop_wait;
      rd_val[canc_pkg::B_INIT_ACK] = s.init_ack;
      rd_val[canc_pkg::B_SLEEP_ACK] = sleep_ack;
    end else if (paddr == canc_pkg::A_CTRL1) begin
      rd_val[canc_pkg::B_MOD_EN] = s.mod_en;
      rd_val[canc_pkg::B_LISTEN] = s.listen;
      rd_val[canc_pkg::B_LOOP] = s.loop;
      rd_val[canc_pkg::B_PDOWN] = s.pdown;
    end else if (paddr == canc_pkg::A_RFLG) begin
      rd_val[canc_pkg::B_WAKE_FLAG] = s.wake_flag;
      rd_val[canc_pkg::B_STATUS_FLAG] = s.status_flag;
      rd_val[canc_pkg::B_OVERRUN] = s.overrun_flag;
      rd_val[canc_pkg::B_RX_FULL] = s.rx_full;
      rd_val[canc_pkg::B_RX_STATE +: 2] = s.rx_state;
      rd_val[canc_pkg::B_TX_STATE +: 2] = s.tx_state;
    end else if (paddr == canc_pkg::A_RIER) begin
      rd_val[3:0] = s.rier;
    end else if (paddr == canc_pkg::A_TFLG) begin
      rd_val[2:0] = s.tx_empty;
      rd_val[canc_pkg::B_ABORT +: 3] = s.abort;
    end else if (paddr == canc_pkg::A_TIER) begin
      rd_val[2:0] = s.tier;
    end else if (paddr == canc_pkg::A_TXERR) begin
      // the engine's count is only stable while it is parked
      if (in_init | sleep_ack) begin
        rd_val[7:0] = mac_in.tec;
      end
    end else if (paddr == canc_pkg::A_RXERR) begin
      if (in_init | sleep_ack) begin
        rd_val[7:0] = mac_in.rec;
      end
    end else if (paddr == canc_pkg::A_FG_ID) begin
      rd_val = s.fg_id;
    end else if (paddr == canc_pkg::A_FG_INFO) begin
      rd_val[0] = s.fg_ide;
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.rx_meta = bus_rx_pin;
    next_s.rx_sync = s.rx_meta;
    next_s.rx_prev = s.rx_sync;
    if (psel && !penable) begin
      next_s.prdata = rd_val;
    end
    // recessive whenever the engine must not reach the wire
    if (s.listen || s.loop || sleep_ack || !s.mod_en) begin
      next_s.tx_pin = 1'b1;
    end else begin
      next_s.tx_pin = mac_in.tx_bit;
    end
    next_s.init_ack = s.init_req;

    // software writes first, so hardware sets below win
    if (wr) begin
      if (paddr == canc_pkg::A_CTRL0) begin
        next_s.init_req = pwdata[canc_pkg::B_INIT_REQ];
        next_s.slp_req = pwdata[canc_pkg::B_SLEEP_REQ];
        next_s.wake_en = pwdata[canc_pkg::B_WAKE_EN];
        next_s.stop_wait = pwdata[canc_pkg::B_STOP_WAIT];
      end
      if (paddr == canc_pkg::A_CTRL1) begin
        next_s.mod_en = pwdata[canc_pkg::B_MOD_EN];
        next_s.listen = pwdata[canc_pkg::B_LISTEN];
        next_s.loop = pwdata[canc_pkg::B_LOOP];
        next_s.pdown = pwdata[canc_pkg::B_PDOWN];
      end
      if (paddr == canc_pkg::A_RFLG) begin
        next_s.wake_flag = s.wake_flag & ~pwdata[canc_pkg::B_WAKE_FLAG];
        next_s.status_flag = s.status_flag & ~pwdata[canc_pkg::B_STATUS_FLAG];
        next_s.overrun_flag = s.overrun_flag & ~pwdata[canc_pkg::B_OVERRUN];
        next_s.rx_full = s.rx_full & ~pwdata[canc_pkg::B_RX_FULL];
      end
      if (paddr == canc_pkg::A_RIER) begin
        next_s.rier = pwdata[3:0];
      end
      if (paddr == canc_pkg::A_TFLG) begin
        next_s.tx_empty = s.tx_empty & ~pwdata[2:0];
        next_s.abort = s.abort | (pwdata[canc_pkg::B_ABORT +: 3] & ~s.tx_empty);
      end
      if (paddr == canc_pkg::A_TIER) begin
        next_s.tier = pwdata[2:0];
      end
      if (in_init && paddr[7:4] == canc_pkg::ACC_PAGE) begin
        next_s.acc[paddr[3:2]] = pwdata[7:0];
      end
      if (in_init && paddr[7:4] == canc_pkg::MSK_PAGE) begin
        next_s.msk[paddr[3:2]] = pwdata[7:0];
      end
    end

    // transmit buffers freed by the engine, sent or aborted
    next_s.tx_empty = next_s.tx_empty | mac_in.tx_done;
    next_s.abort = next_s.abort & ~mac_in.tx_done;

    // receive path: background, one queued slot, foreground
    next_s.bg_new = mac_in.rx_done;
    if (mac_in.rx_done) begin
      next_s.bg_id = mac_in.rx_id;
      next_s.bg_ide = mac_in.rx_ide;
    end
    if (move) begin
      next_s.fg_id = s.pend_id;
      next_s.fg_ide = s.pend_ide;
      next_s.rx_full = 1'b1;
      next_s.pend_valid = 1'b0;
    end
    if (accept) begin
      if (!s.pend_valid || move) begin
        next_s.pend_id = s.bg_id;
        next_s.pend_ide = s.bg_ide;
        next_s.pend_valid = 1'b1;
      end else begin
        next_s.overrun_flag = 1'b1;
      end
    end

    if (rx_state_now != s.rx_state || tx_state_now != s.tx_state) begin
      next_s.rx_state = rx_state_now;
      next_s.tx_state = tx_state_now;
      next_s.status_flag = 1'b1;
    end

    // dominant edge on the wire while asleep with wake-up enabled
    if (sleep_ack && s.wake_en && s.rx_prev && !s.rx_sync) begin
      next_s.wake_flag = 1'b1;
    end

    unique case (s.phase)
      canc_pkg::S_RUN: begin
        if (s.slp_req && s.mod_en) begin
          next_s.phase = canc_pkg::S_DRAIN;
        end
      end
      canc_pkg::S_DRAIN: begin
        if (!s.slp_req) begin
          next_s.phase = canc_pkg::S_RUN;
        end else if ((&s.tx_empty) && mac_in.bus_idle) begin
          next_s.phase = canc_pkg::S_SYNC;
          next_s.sync_cnt = '0;
        end
      end
      canc_pkg::S_SYNC: begin
        if (!s.slp_req) begin
          next_s.phase = canc_pkg::S_RUN;
        end else if (s.sync_cnt == canc_pkg::SYNC_LAST) begin
          next_s.phase = canc_pkg::S_SLEEP;
        end else begin
          next_s.sync_cnt = s.sync_cnt + 3'h1;
        end
      end
      canc_pkg::S_SLEEP: begin
        // acknowledge holds while the request stays set
        if (!s.slp_req) begin
          next_s.phase = canc_pkg::S_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= canc_pkg::STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign bus_tx_pin = s.tx_pin;

  always_comb begin
    mac_out.tx_request = ~s.tx_empty & {3{tx_allowed}};
    mac_out.abort_request = s.abort & {3{~sleep_ack}};
    mac_out.ignore_ack = s.loop;
    if (s.loop) begin
      mac_out.rx_bit = mac_in.tx_bit;
    end else if (s.listen) begin
      // own dominant bits seen by the engine only
      mac_out.rx_bit = s.rx_sync & mac_in.tx_bit;
    end else begin
      mac_out.rx_bit = s.rx_sync;
    end
    // engine clock off when disabled, asleep, down, or waiting with stop-in-wait set
    mac_out.clk_run = s.mod_en & ~s.pdown & ~sleep_ack &
      ~(cpu_wait & s.stop_wait);
  end

  assign reg_clk_run = s.mod_en & ~s.pdown;

  assign irq_wakeup = s.wake_flag & s.rier[canc_pkg::RIE_WUP];
  assign irq_error = (s.status_flag & s.rier[canc_pkg::RIE_CSC]) |
    (s.overrun_flag & s.rier[canc_pkg::RIE_OVR]);
  assign irq_rx = s.rx_full & s.rier[canc_pkg::RIE_RX_FULL];
  assign irq_tx = |(s.tx_empty & s.tier);

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence sync_held;
    (s.phase == canc_pkg::S_SYNC && s.slp_req) [*4];
  endsequence

  sequence tec_read_parked_out;
    psel && !penable && !pwrite && paddr == canc_pkg::A_TXERR && !in_init && !sleep_ack;
  endsequence

  listen_pin_recessive_a: assert property (s.listen |=> bus_tx_pin)
    else $error("listen-only drove the transmit pin dominant");
  listen_no_start_a: assert property (s.listen |-> mac_out.tx_request == 3'h0)
    else $error("listen-only requested a transmission");
  loop_feedback_a: assert property (s.loop |-> mac_out.rx_bit == mac_in.tx_bit)
    else $error("loopback receive bit not fed from transmitter");
  acc_write_lock_a: assert property (
    (wr && paddr[7:4] == canc_pkg::ACC_PAGE && !in_init) |=> $stable(s.acc))
    else $error("acceptance register changed outside init");
  tec_read_zero_a: assert property (tec_read_parked_out |=> prdata == 32'h0)
    else $error("error count returned outside sleep or init");
  sleep_entry_a: assert property (sync_held |=> sleep_ack)
    else $error("sleep not entered after the sync delay");
  sleep_drain_a: assert property (
    (s.phase == canc_pkg::S_DRAIN && !(&s.tx_empty)) |=> !sleep_ack)
    else $error("sleep entered with a buffer still scheduled");
  wake_flag_a: assert property (
    (sleep_ack && s.wake_en && s.rx_prev && !s.rx_sync) |=> s.wake_flag)
    else $error("bus activity in sleep did not set wake flag");
  fg_hold_sleep_a: assert property (sleep_ack |=> $stable(s.fg_id))
    else $error("foreground buffer loaded during sleep");

endmodule

// ==== verification/canc_peer_model.sv ====
`timescale 1ns/1ps
// stand-in for the protocol engine and the other bus nodes
module canc_peer_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench commands
  input wire logic go,
  input wire logic [31:0] fid,
  input wire logic fide,
  input wire logic [7:0] tec,
  input wire logic txb,
  input wire logic slow,
  // block side
  input wire canc_pkg::canc_mac_out_t mac_out,
  output canc_pkg::canc_mac_in_t mac_in
);
  logic [2:0] busy;
  logic [2:0] done;
  logic [5:0] cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 3'h0;
      done <= 3'h0;
      cnt <= 6'h0;
    end else begin
      done <= 3'h0;
      // one idle cycle after done, so a stale request is not sent twice
      if (busy == 3'h0 && done == 3'h0 && mac_out.tx_request != 3'h0) begin
        busy <= mac_out.tx_request & ~(mac_out.tx_request - 3'h1);
        cnt <= slow ? 6'h28 : 6'h03;
      end else if (busy != 3'h0) begin
        if (cnt == 6'h0 || (mac_out.abort_request & busy) != 3'h0) begin
          done <= busy;
          busy <= 3'h0;
        end else begin
          cnt <= cnt - 6'h1;
        end
      end
    end
  end

  assign mac_in.tx_bit = txb;
  assign mac_in.bus_idle = busy == 3'h0;
  assign mac_in.rx_done = go;
  assign mac_in.rx_ide = fide;
  // identifier means nothing outside the pulse, so it is scrambled there
  assign mac_in.rx_id = go ? fid : ~fid;
  assign mac_in.tx_done = done;
  assign mac_in.tec = tec;
  assign mac_in.rec = 8'h00;
  assign mac_in.bus_off = 1'b0;
endmodule

// ==== verification/can_controller_modes_irq_tb_top.sv ====
`timescale 1ns/1ps
module can_controller_modes_irq_tb_top;
  logic mclk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_rx_pin;
  logic bus_tx_pin;
  logic cpu_wait;
  logic reg_clk_run;
  logic irq_wakeup;
  logic irq_error;
  logic irq_rx;
  logic irq_tx;
  logic go;
  logic fide;
  logic txb;
  logic slow;
  logic lerr;
  logic [7:0] tec;
  logic [31:0] fid;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] id2;
  logic [31:0] rdv;
  logic [31:0] exp_v;
  logic [31:0] exp_q[$];
  int err_count;
  int checks;
  canc_pkg::canc_mac_in_t mac_in;
  canc_pkg::canc_mac_out_t mac_out;

  canc_core dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_rx_pin),
    .bus_tx_pin(bus_tx_pin), .mac_in(mac_in), .mac_out(mac_out),
    .cpu_wait(cpu_wait), .reg_clk_run(reg_clk_run), .irq_wakeup(irq_wakeup),
    .irq_error(irq_error), .irq_rx(irq_rx), .irq_tx(irq_tx));

  canc_peer_model peer_u (.mclk(mclk), .rst(rst), .go(go), .fid(fid),
    .fide(fide), .tec(tec), .txb(txb), .slow(slow), .mac_out(mac_out),
    .mac_in(mac_in));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    rdv = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic frame(input logic [31:0] id, input logic ide, input int n);
    fid <= id;
    fide <= ide;
    go <= 1'b1;
    repeat (n) @(posedge mclk);
    go <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // read data is judged where the access completes
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      chk($sformatf("read %h", paddr), exp_v, prdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_rx_pin = 1'b1;
    cpu_wait = 1'b0;
    go = 1'b0;
    fide = 1'b0;
    fid = 32'h0;
    txb = 1'b1;
    slow = 1'b0;
    tec = 8'h05;
    seed = 32'h855e37a2;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(canc_pkg::A_CTRL0, 32'h101);
    rd(canc_pkg::A_TFLG, 32'h7);
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, lerr});
    chk("engine clock", 32'h0, {31'h0, mac_out.clk_run});
    seed = xs(seed);
    r = seed;
    for (int i = 0; i < 4; i++) begin
      wr({canc_pkg::ACC_PAGE, 2'(i), 2'b00}, {24'h0, r[31 - 8 * i -: 8]});
    end
    wr({canc_pkg::MSK_PAGE, 4'h4}, 32'h0f);
    rd({canc_pkg::ACC_PAGE, 4'h0}, {24'h0, r[31:24]});
    rd(canc_pkg::A_TXERR, 32'h5);
    wr(canc_pkg::A_TXERR, 32'hff);
    rd(canc_pkg::A_TXERR, 32'h5);
    wr(canc_pkg::A_CTRL0, 32'h0);
    wr(canc_pkg::A_CTRL1, 32'h1);
    rd(canc_pkg::A_TXERR, 32'h0);
    wr({canc_pkg::ACC_PAGE, 4'h0}, {24'h0, ~r[31:24]});
    rd({canc_pkg::ACC_PAGE, 4'h0}, {24'h0, r[31:24]});
    ////////////////////////////////////////////////////////////////////////
    wr(canc_pkg::A_RIER, 32'hf);
    frame(r, 1'b1, 1);
    rd(canc_pkg::A_RFLG, 32'h8);
    rd(canc_pkg::A_FG_ID, r);
    @(negedge mclk);
    chk("irq_rx set", 32'h1, {31'h0, irq_rx});
    @(posedge mclk);
    wr(canc_pkg::A_RFLG, 32'h8);
    @(negedge mclk);
    chk("irq_rx clear", 32'h0, {31'h0, irq_rx});
    @(posedge mclk);
    id2 = {r[31:24], r[23:16] ^ 8'h05, ~r[15:0]};
    frame(id2, 1'b0, 1);
    rd(canc_pkg::A_RFLG, 32'h8);
    rd(canc_pkg::A_FG_ID, id2);
    wr(canc_pkg::A_RFLG, 32'h8);
    frame(r ^ 32'h1, 1'b1, 1);
    frame({~r[31:24], r[23:0]}, 1'b0, 1);
    rd(canc_pkg::A_RFLG, 32'h0);
    rd(canc_pkg::A_FG_ID, id2);
    frame(r, 1'b1, 3);
    rd(canc_pkg::A_RFLG, 32'hc);
    @(negedge mclk);
    chk("irq_error", 32'h1, {31'h0, irq_error});
    @(posedge mclk);
    wr(canc_pkg::A_RFLG, 32'hc);
    rd(canc_pkg::A_RFLG, 32'h8);
    wr(canc_pkg::A_RFLG, 32'h8);
    tec <= 8'h60;
    repeat (3) @(posedge mclk);
    rd(canc_pkg::A_RFLG, 32'h42);
    wr(canc_pkg::A_RFLG, 32'h2);
    rd(canc_pkg::A_RFLG, 32'h40);
    ////////////////////////////////////////////////////////////////////////
    slow <= 1'b1;
    wr(canc_pkg::A_TIER, 32'h1);
    wr(canc_pkg::A_TFLG, 32'h1);
    rd(canc_pkg::A_TFLG, 32'h6);
    @(negedge mclk);
    chk("irq_tx busy", 32'h0, {31'h0, irq_tx});
    @(posedge mclk);
    repeat (60) @(posedge mclk);
    rd(canc_pkg::A_TFLG, 32'h7);
    @(negedge mclk);
    chk("irq_tx empty", 32'h1, {31'h0, irq_tx});
    @(posedge mclk);
    slow <= 1'b0;
    txb <= 1'b0;
    wr(canc_pkg::A_CTRL1, 32'h3);
    wr(canc_pkg::A_TFLG, 32'h2);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("listen start", 32'h0, {29'h0, mac_out.tx_request});
    chk("listen pin", 32'h1, {31'h0, bus_tx_pin});
    chk("listen loop", 32'h0, {31'h0, mac_out.rx_bit});
    @(posedge mclk);
    wr(canc_pkg::A_CTRL1, 32'h1);
    @(negedge mclk);
    chk("normal pin", 32'h0, {31'h0, bus_tx_pin});
    @(posedge mclk);
    repeat (20) @(posedge mclk);
    rd(canc_pkg::A_TFLG, 32'h7);
    wr(canc_pkg::A_CTRL1, 32'h5);
    @(negedge mclk);
    chk("loop rx", 32'h0, {31'h0, mac_out.rx_bit});
    chk("loop pin", 32'h1, {31'h0, bus_tx_pin});
    chk("loop ack", 32'h1, {31'h0, mac_out.ignore_ack});
    @(posedge mclk);
    txb <= 1'b1;
    bus_rx_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("loop rx pin ignored", 32'h1, {31'h0, mac_out.rx_bit});
    @(posedge mclk);
    bus_rx_pin <= 1'b1;
    wr(canc_pkg::A_CTRL1, 32'h1);
    // stop-in-wait gates the engine only while the cpu waits
    wr(canc_pkg::A_CTRL0, 32'h8);
    rd(canc_pkg::A_CTRL0, 32'h8);
    cpu_wait <= 1'b1;
    @(negedge mclk);
    chk("wait engine clock", 32'h0, {31'h0, mac_out.clk_run});
    @(posedge mclk);
    cpu_wait <= 1'b0;
    @(negedge mclk);
    chk("run engine clock", 32'h1, {31'h0, mac_out.clk_run});
    @(posedge mclk);
    wr(canc_pkg::A_CTRL0, 32'h0);
    // abort frees a long transfer well before it could finish
    slow <= 1'b1;
    wr(canc_pkg::A_TFLG, 32'h1);
    wr(canc_pkg::A_TFLG, 32'h100);
    repeat (2) @(posedge mclk);
    rd(canc_pkg::A_TFLG, 32'h7);
    ////////////////////////////////////////////////////////////////////////
    slow <= 1'b1;
    wr(canc_pkg::A_TFLG, 32'h1);
    // let the transfer start before asking for sleep
    repeat (5) @(posedge mclk);
    wr(canc_pkg::A_CTRL0, 32'h6);
    rd(canc_pkg::A_CTRL0, 32'h6);
    for (int i = 0; i < 200 && rdv[9] !== 1'b1; i++) begin
      apb(1'b0, canc_pkg::A_CTRL0, 32'h0);
    end
    if (rdv[9] !== 1'b1) begin
      err_count++;
      close_out();
    end
    rd(canc_pkg::A_CTRL0, 32'h206);
    rd(canc_pkg::A_TFLG, 32'h7);
    rd(canc_pkg::A_TXERR, 32'h60);
    @(negedge mclk);
    chk("sleep engine clock", 32'h0, {31'h0, mac_out.clk_run});
    chk("sleep reg clock", 32'h1, {31'h0, reg_clk_run});
    chk("sleep pin", 32'h1, {31'h0, bus_tx_pin});
    @(posedge mclk);
    frame(r, 1'b1, 1);
    rd(canc_pkg::A_RFLG, 32'h40);
    bus_rx_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(canc_pkg::A_RFLG, 32'h41);
    @(negedge mclk);
    chk("irq_wakeup", 32'h1, {31'h0, irq_wakeup});
    @(posedge mclk);
    bus_rx_pin <= 1'b1;
    wr(canc_pkg::A_CTRL0, 32'h0);
    wr(canc_pkg::A_RFLG, 32'h1);
    rd(canc_pkg::A_RFLG, 32'h48);
    wr(canc_pkg::A_CTRL1, 32'h9);
    @(negedge mclk);
    chk("pdown reg clock", 32'h0, {31'h0, reg_clk_run});
    chk("pdown engine clock", 32'h0, {31'h0, mac_out.clk_run});
    @(posedge mclk);
    close_out();
  end
endmodule
